//--- pcpdh_monitor.sv
// checker of the power-down hold block
`timescale 1ns/100ps
`default_nettype none
module pcpdh_monitor
#(parameter bit PD_ENABLE = 1'b1)
(
    input wire logic       MCLK,              // clock
    input wire logic       RST,               // reset
    input wire logic       SLEEP_REQUEST_PIN, // sleep request
    input wire logic [7:0] CORE_DATA,         // array data
    input wire logic [7:0] ARRAY_IN,          // gated inputs
    input wire logic [7:0] ARRAY_IO,          // gated pins
    input wire logic [7:0] CORE_REG_Q,        // held state
    input wire logic [7:0] IO_OUT,            // pin data
    input wire logic [7:0] IO_OE,             // pin enables
    input wire logic       ASLEEP,            // in power-down
    input wire logic       WAKE_VALID         // normal operation
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (RST);
    logic req_d_ff;
    // sleep state is exactly the request seen at the last edge
    always_ff @(posedge MCLK)
    begin
        req_d_ff <= SLEEP_REQUEST_PIN && !RST;
    end
    wire frz = PD_ENABLE && (SLEEP_REQUEST_PIN || req_d_ff);
    a_sleep_entry:
        assert property (PD_ENABLE && SLEEP_REQUEST_PIN |=> ASLEEP) else $error("no sleep");
    a_sleep_exit:
        assert property (!frz |=> !ASLEEP) else $error("asleep stuck");
    a_hold_output:
        assert property (frz |=> $stable(IO_OUT)) else $error("output moved");
    a_hold_state:
        assert property (frz |=> $stable(CORE_REG_Q)) else $error("state moved");
    a_hold_hiz:
        assert property (frz |=> $stable(IO_OE)) else $error("enable moved");
    a_block_inputs:
        assert property (frz |=> $stable(ARRAY_IN)) else $error("input passed");
    a_pin_latch:
        assert property (frz |=> $stable(ARRAY_IO)) else $error("pin latch moved");
    a_run_sample:
        assert property (!frz |=> IO_OUT == $past(CORE_DATA)) else $error("not sampled");
    a_wake_bound:
        assert property ($fell(SLEEP_REQUEST_PIN) |-> ##[1:104] (WAKE_VALID || SLEEP_REQUEST_PIN))
            else $error("slow wake");
    a_sleep_invalid:
        assert property (ASLEEP |-> !WAKE_VALID) else $error("valid in sleep");
    a_off_ignore:
        assert property (!PD_ENABLE |-> !ASLEEP) else $error("sleep when off");
endmodule : pcpdh_monitor
bind pcpdh_top pcpdh_monitor #(.PD_ENABLE(PD_ENABLE)) pcpdh_monitor_i (.MCLK, .RST,
    .SLEEP_REQUEST_PIN, .CORE_DATA, .ARRAY_IN, .ARRAY_IO, .CORE_REG_Q, .IO_OUT, .IO_OE,
    .ASLEEP, .WAKE_VALID);
`default_nettype wire

//--- pcpdh_partner.sv
// far-side model: sleep pin and a moving input pattern
`timescale 1ns/100ps
`default_nettype none
module pcpdh_partner
(
    input  wire logic       mclk,      // clock
    input  wire logic       sleep_cmd, // bench order
    output var  logic       sleep_req, // sleep pin
    output var  logic [7:0] pat        // input pattern
);
    logic [7:0] cnt_ff = 8'h00;
    // level only, sleep_req follows sleep_cmd with no delay
    assign sleep_req = sleep_cmd;
    always @(negedge mclk) cnt_ff <= cnt_ff + 8'h1d;
    assign pat = cnt_ff;
endmodule : pcpdh_partner
`default_nettype wire

//--- pcpdh_pkg.sv
// package of constants for the pin-controlled power-down hold block
package pcpdh_pkg;
    // ****************************************
    // widths
    // ****************************************
    localparam int DATA_W = 8;
    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_HZ          = 100_000_000;
    localparam int WAKE_TIME_NS    = 1000;
    // longest time: round down, at least one cycle
    localparam int WAKE_CYCLES_RAW = (WAKE_TIME_NS * (CLK_HZ / 1_000_000)) / 1000;
    localparam int WAKE_CYCLES     = (WAKE_CYCLES_RAW < 1) ? 1 : WAKE_CYCLES_RAW;
    localparam int WAKE_CNT_W      = 8;
    // ****************************************
    // reset values
    // ****************************************
    localparam logic [DATA_W-1:0] RST_DATA = 8'h00;
    localparam logic [DATA_W-1:0] RST_OE   = 8'h00;
    localparam logic              RST_FLAG = 1'b0;
    // ****************************************
    // states
    // ****************************************
    typedef enum logic [1:0]
    {
        PCPDH_RUN   = 2'b00,
        PCPDH_SLEEP = 2'b01,
        PCPDH_WAKE  = 2'b11
    } pcpdh_state_e;
endpackage : pcpdh_pkg

//--- pcpdh_top.sv
// power-down hold logic: freezes state and pins while the sleep request is high
`timescale 1ns/100ps
`default_nettype none
module pcpdh_top
#(
    parameter bit PD_ENABLE = 1'b1
)
(
    input  wire logic                         MCLK,              // 100 MHz clock
    input  wire logic                         RST,               // sync reset, high
    input  wire logic                         SLEEP_REQUEST_PIN, // sleep request
    input  wire logic [pcpdh_pkg::DATA_W-1:0] LOGIC_IN,          // dedicated inputs
    input  wire logic [pcpdh_pkg::DATA_W-1:0] IO_IN,             // two-way pin levels
    input  wire logic [pcpdh_pkg::DATA_W-1:0] CORE_DATA,         // array data to drive
    input  wire logic [pcpdh_pkg::DATA_W-1:0] CORE_OE,           // array output enables
    input  wire logic [pcpdh_pkg::DATA_W-1:0] CORE_REG_D,        // array register next state
    output var  logic [pcpdh_pkg::DATA_W-1:0] ARRAY_IN,          // gated inputs to array
    output var  logic [pcpdh_pkg::DATA_W-1:0] ARRAY_IO,          // gated pin levels to array
    output var  logic [pcpdh_pkg::DATA_W-1:0] CORE_REG_Q,        // held array register state
    output var  logic [pcpdh_pkg::DATA_W-1:0] IO_OUT,            // pin output data
    output var  logic [pcpdh_pkg::DATA_W-1:0] IO_OE,             // pin output enables
    output var  logic                         ASLEEP,            // in power-down
    output var  logic                         WAKE_VALID         // normal operation valid
);

    // ****************************************
    // sleep control
    // ****************************************
    pcpdh_pkg::pcpdh_state_e                state_ff;
    pcpdh_pkg::pcpdh_state_e                nxt_state;
    logic [pcpdh_pkg::WAKE_CNT_W-1:0]       wake_cnt_ff;
    logic [pcpdh_pkg::WAKE_CNT_W-1:0]       nxt_wake_cnt;
    logic                                   sleep_req;
    logic                                   frozen;

    assign sleep_req = PD_ENABLE & SLEEP_REQUEST_PIN;

    always_comb
    begin
        nxt_state    = state_ff;
        nxt_wake_cnt = wake_cnt_ff;
        case (state_ff)
            pcpdh_pkg::PCPDH_RUN:
            begin
                if (sleep_req)
                begin
                    nxt_state = pcpdh_pkg::PCPDH_SLEEP;
                end
            end
            pcpdh_pkg::PCPDH_SLEEP:
            begin
                if (!sleep_req)
                begin
                    nxt_state    = pcpdh_pkg::PCPDH_WAKE;
                    nxt_wake_cnt = pcpdh_pkg::WAKE_CNT_W'(pcpdh_pkg::WAKE_CYCLES - 1);
                end
            end
            pcpdh_pkg::PCPDH_WAKE:
            begin
                if (sleep_req)
                begin
                    nxt_state = pcpdh_pkg::PCPDH_SLEEP;
                end
                else if (wake_cnt_ff == '0)
                begin
                    nxt_state = pcpdh_pkg::PCPDH_RUN;
                end
                else
                begin
                    nxt_wake_cnt = wake_cnt_ff - 1'b1;
                end
            end
            default:
            begin
                nxt_state = pcpdh_pkg::PCPDH_RUN;
            end
        endcase
        if (RST)
        begin
            nxt_state    = pcpdh_pkg::PCPDH_RUN;
            nxt_wake_cnt = '0;
        end
    end

    always_ff @(posedge MCLK)
    begin
        state_ff    <= nxt_state;
        wake_cnt_ff <= nxt_wake_cnt;
    end

    // freeze from the request edge itself, and while asleep
    assign frozen = sleep_req | (state_ff == pcpdh_pkg::PCPDH_SLEEP);

    // ****************************************
    // input hold
    // ****************************************
    logic [pcpdh_pkg::DATA_W-1:0] arr_in_ff;
    logic [pcpdh_pkg::DATA_W-1:0] nxt_arr_in;
    logic [pcpdh_pkg::DATA_W-1:0] arr_io_ff;
    logic [pcpdh_pkg::DATA_W-1:0] nxt_arr_io;

    always_comb
    begin
        nxt_arr_in = arr_in_ff;
        nxt_arr_io = arr_io_ff;
        if (!frozen)
        begin
            nxt_arr_in = LOGIC_IN;
        end
        if (!frozen)
        begin
            nxt_arr_io = IO_IN;
        end
        if (RST)
        begin
            nxt_arr_in = pcpdh_pkg::RST_DATA;
            nxt_arr_io = pcpdh_pkg::RST_DATA;
        end
    end

    always_ff @(posedge MCLK)
    begin
        arr_in_ff <= nxt_arr_in;
        arr_io_ff <= nxt_arr_io;
    end

    // ****************************************
    // array register state hold
    // ****************************************
    logic [pcpdh_pkg::DATA_W-1:0] reg_q_ff;
    logic [pcpdh_pkg::DATA_W-1:0] nxt_reg_q;

    always_comb
    begin
        nxt_reg_q = reg_q_ff;
        if (!frozen)
        begin
            nxt_reg_q = CORE_REG_D;
        end
        if (RST)
        begin
            nxt_reg_q = pcpdh_pkg::RST_DATA;
        end
    end

    always_ff @(posedge MCLK)
    begin
        reg_q_ff <= nxt_reg_q;
    end

    // ****************************************
    // pin drive hold
    // ****************************************
    logic [pcpdh_pkg::DATA_W-1:0] out_ff;
    logic [pcpdh_pkg::DATA_W-1:0] nxt_out;
    logic [pcpdh_pkg::DATA_W-1:0] oe_ff;
    logic [pcpdh_pkg::DATA_W-1:0] nxt_oe;

    always_comb
    begin
        nxt_out = out_ff;
        nxt_oe  = oe_ff;
        if (!frozen)
        begin
            nxt_out = CORE_DATA;
        end
        if (!frozen)
        begin
            nxt_oe = CORE_OE;
        end
        if (RST)
        begin
            nxt_out = pcpdh_pkg::RST_DATA;
            nxt_oe  = pcpdh_pkg::RST_OE;
        end
    end

    always_ff @(posedge MCLK)
    begin
        out_ff <= nxt_out;
        oe_ff  <= nxt_oe;
    end

    // ****************************************
    // status flags
    // ****************************************
    logic                         asleep_ff;
    logic                         nxt_asleep;
    logic                         valid_ff;
    logic                         nxt_valid;

    always_comb
    begin
        nxt_asleep = frozen;
        nxt_valid  = !frozen && (state_ff == pcpdh_pkg::PCPDH_RUN);
        if (RST)
        begin
            nxt_asleep = pcpdh_pkg::RST_FLAG;
            nxt_valid  = pcpdh_pkg::RST_FLAG;
        end
    end

    always_ff @(posedge MCLK)
    begin
        asleep_ff <= nxt_asleep;
        valid_ff  <= nxt_valid;
    end

    // ****************************************
    // outputs
    // ****************************************
    // every port straight from its flip-flop
    assign ARRAY_IN   = arr_in_ff;
    assign ARRAY_IO   = arr_io_ff;
    assign CORE_REG_Q = reg_q_ff;
    assign IO_OUT     = out_ff;
    assign IO_OE      = oe_ff;
    assign ASLEEP     = asleep_ff;
    assign WAKE_VALID = valid_ff;

endmodule : pcpdh_top
`default_nettype wire

//--- tb_pcpdh_top.sv
// bench for the power-down hold block
`timescale 1ns/100ps
`default_nettype none
module tb_pcpdh_top;
    logic       mclk = 1'b0;
    logic       rst = 1'b1;
    logic       cmd = 1'b0;
    logic       req, slp, wv, slp_off;
    logic [7:0] pat, a_in, a_io, rq, o, oen, o_off;
    int         n_errors = 0;
    int         check_count = 0;
    int         n;
    wire [7:0]  li = pat;
    wire [7:0]  io = ~pat;
    wire [7:0]  cd = pat ^ 8'h5a;
    wire [7:0]  rd = {pat[3:0], pat[7:4]};
    wire [39:0] all_i = {cd, pat, rd, li, io};
    wire [39:0] all_o = {o, oen, rq, a_in, a_io};
    always #5 mclk = ~mclk;
    pcpdh_partner pcpdh_partner_i (.mclk(mclk), .sleep_cmd(cmd), .sleep_req(req), .pat(pat));
    pcpdh_top pcpdh_top_i (.MCLK(mclk), .RST(rst), .SLEEP_REQUEST_PIN(req), .LOGIC_IN(li),
        .IO_IN(io), .CORE_DATA(cd), .CORE_OE(pat), .CORE_REG_D(rd), .ARRAY_IN(a_in),
        .ARRAY_IO(a_io), .CORE_REG_Q(rq), .IO_OUT(o), .IO_OE(oen), .ASLEEP(slp), .WAKE_VALID(wv));
    pcpdh_top #(.PD_ENABLE(1'b0)) pcpdh_top_off_i (.MCLK(mclk), .RST(rst),
        .SLEEP_REQUEST_PIN(req), .LOGIC_IN(li), .IO_IN(io), .CORE_DATA(cd), .CORE_OE(pat),
        .CORE_REG_D(rd), .ARRAY_IN(), .ARRAY_IO(), .CORE_REG_Q(), .IO_OUT(o_off), .IO_OE(),
        .ASLEEP(slp_off), .WAKE_VALID());
    task automatic chk(input string nm, input logic [39:0] e, input logic [39:0] g);
        check_count++;
        if (g !== e)
        begin
            n_errors++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task automatic print_verdict();
        if (n_errors == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : print_verdict
    task automatic t_run();
        repeat (3)
        begin
            @(negedge mclk);
            chk("run", all_i, all_o);
            chk("valid", 1, wv);
        end
    endtask : t_run
    task automatic t_sleep();
        logic [39:0] s;
        @(negedge mclk);
        cmd = 1'b1;
        s = all_o;
        repeat (20)
        begin
            @(negedge mclk);
            chk("held", s, all_o);
            chk("asleep", 2'b10, {slp, wv});
            chk("off", {cd, 1'b0}, {o_off, slp_off});
        end
    endtask : t_sleep
    task automatic t_rereq();
        cmd = 1'b0;
        repeat (10) @(negedge mclk);
        cmd = 1'b1;
        repeat (2) @(negedge mclk);
        chk("resleep", 2'b10, {slp, wv});
    endtask : t_rereq
    task automatic t_wake();
        cmd = 1'b0;
        repeat (2) @(negedge mclk);
        chk("resume", {all_i, 1'b0}, {all_o, slp});
        n = 2;
        while (wv !== 1'b1 && n < 300)
        begin
            @(negedge mclk);
            n++;
        end
        chk("wake_time", 1, n >= pcpdh_pkg::WAKE_CYCLES && n <= pcpdh_pkg::WAKE_CYCLES + 4);
    endtask : t_wake
    task automatic t_reset();
        cmd = 1'b1;
        rst = 1'b1;
        repeat (2) @(negedge mclk);
        chk("mid_reset", 0, all_o);
        chk("mid_flags", 0, {slp, wv});
        rst = 1'b0;
        repeat (2) @(negedge mclk);
        chk("reset_hold", 0, all_o);
        chk("asleep", 2'b10, {slp, wv});
        chk("off", {cd, 1'b0}, {o_off, slp_off});
    endtask : t_reset
    initial
    begin
        repeat (4) @(negedge mclk);
        chk("reset", 0, {o, oen, rq, slp, wv});
        rst = 1'b0;
        t_run();
        t_sleep();
        t_rereq();
        t_wake();
        t_run();
        t_reset();
        t_wake();
        t_run();
        print_verdict();
    end
    initial
    begin
        #20000;
        n_errors++;
        print_verdict();
    end
endmodule : tb_pcpdh_top
`default_nettype wire
